// *** jtag_dr_cfg.svh ***
`ifndef JTAG_DR_CFG_SVH
`define JTAG_DR_CFG_SVH

// ==========================================================================
// Instruction register
`define IR_WIDTH        7
`define IR_CAPTURE      7'h01
`define OP_EXTEST       7'h00
`define OP_SAMPLE       7'h01
`define OP_IDCODE       7'h02
`define OP_CLAMP        7'h04
`define OP_HIGHZ        7'h08
`define OP_BYPASS       7'h7f

// ==========================================================================
// Identification value fields (values arbitrary)
`define ID_WIDTH        32
`define ID_VERSION      4'h2
`define ID_SEGMENT      6'h01
`define ID_PTYPE        5'h02
`define ID_COMPONENT    5'h03
`define ID_MAKER        11'h055
`define ID_FIXED_BIT    1'h1

// ==========================================================================
// Boundary-scan pin counts
`define BS_IN_PINS      4
`define BS_OUT_PINS     4
`define BS_IO_PINS      2
`define BS_LEN          (`BS_IN_PINS + `BS_OUT_PINS + 2 * `BS_IO_PINS)

// ==========================================================================
// Timing: test clock period and its length in system clocks
`define TCK_PERIOD_NS   125
`define CLK_PERIOD_NS   5
`define TCK_CYCLES      (`TCK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// *** jtag_dr_pkg.sv ***
package jtag_dr_pkg;

  // ========================================================================
  // Test access port controller states
  typedef enum logic [3:0] {
    TestLogicReset, RunTestIdle,
    SelectDrScan, CaptureDr, ShiftDr, Exit1Dr, PauseDr, Exit2Dr, UpdateDr,
    SelectIrScan, CaptureIr, ShiftIr, Exit1Ir, PauseIr, Exit2Ir, UpdateIr
  } tap_state_type;

endpackage : jtag_dr_pkg

// *** jtag_pin_sync.sv ***
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser for pins from outside the clock domain
module jtag_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : jtag_pin_sync

// *** jtag_data_register_path.sv ***
`timescale 1ns/1ps
`include "jtag_dr_cfg.svh"

module jtag_data_register_path (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       tckPin,
  input  wire logic                       tmsPin,
  input  wire logic                       tdiPin,
  input  wire logic                       trstNPin,
  output logic                            tdoOut,
  output logic                            tdoOeN,
  output jtag_dr_pkg::tap_state_type      tapState,
  input  wire logic [`BS_IN_PINS-1:0]     inPin,
  output logic      [`BS_IN_PINS-1:0]     coreIn,
  input  wire logic [`BS_OUT_PINS-1:0]    coreOut,
  output logic      [`BS_OUT_PINS-1:0]    outPin,
  output logic      [`BS_OUT_PINS-1:0]    outPinOeN,
  input  wire logic [`BS_IO_PINS-1:0]     coreIoOut,
  input  wire logic [`BS_IO_PINS-1:0]     coreIoOeN,
  output logic      [`BS_IO_PINS-1:0]     coreIoIn,
  input  wire logic [`BS_IO_PINS-1:0]     ioPinIn,
  output logic      [`BS_IO_PINS-1:0]     ioPinOut,
  output logic      [`BS_IO_PINS-1:0]     ioPinOeN
);
  import jtag_dr_pkg::*;

  localparam int NI  = `BS_IN_PINS;
  localparam int NO  = `BS_OUT_PINS;
  localparam int NB  = `BS_IO_PINS;
  localparam int L   = `BS_LEN;
  localparam int SW  = 4 + NI + NB;
  localparam int IDW = `ID_WIDTH;
  localparam logic [IDW-1:0] ID_VALUE = {`ID_VERSION, `ID_SEGMENT, `ID_PTYPE,
                                         `ID_COMPONENT, `ID_MAKER,
                                         `ID_FIXED_BIT};

  // ========================================================================
  // Pin synchronisers and test clock edges
  logic [SW-1:0]   syncQ;
  logic            tckS;
  logic            tmsS;
  logic            tdiS;
  logic            trstNS;
  logic [NI-1:0]   inS;
  logic [NB-1:0]   ioS;
  logic            tckPrev_q;
  logic            tckRise;
  logic            tckFall;

  jtag_pin_sync #(.W(SW)) pinSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({tckPin, tmsPin, tdiPin, trstNPin, inPin, ioPinIn}),
    .q       (syncQ)
  );

  assign {tckS, tmsS, tdiS, trstNS, inS, ioS} = syncQ;
  assign tckRise = tckS & ~tckPrev_q;
  assign tckFall = ~tckS & tckPrev_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tckPrev_q <= 1'h0;
    end else begin
      tckPrev_q <= tckS;
    end
  end

  // ========================================================================
  // TAP controller
  tap_state_type state_q;
  tap_state_type state_d;

  always_comb begin
    unique case (state_q)
      TestLogicReset: state_d = tmsS ? TestLogicReset : RunTestIdle;
      RunTestIdle:    state_d = tmsS ? SelectDrScan : RunTestIdle;
      SelectDrScan:   state_d = tmsS ? SelectIrScan : CaptureDr;
      CaptureDr:      state_d = tmsS ? Exit1Dr : ShiftDr;
      ShiftDr:        state_d = tmsS ? Exit1Dr : ShiftDr;
      Exit1Dr:        state_d = tmsS ? UpdateDr : PauseDr;
      PauseDr:        state_d = tmsS ? Exit2Dr : PauseDr;
      Exit2Dr:        state_d = tmsS ? UpdateDr : ShiftDr;
      UpdateDr:       state_d = tmsS ? SelectDrScan : RunTestIdle;
      SelectIrScan:   state_d = tmsS ? TestLogicReset : CaptureIr;
      CaptureIr:      state_d = tmsS ? Exit1Ir : ShiftIr;
      ShiftIr:        state_d = tmsS ? Exit1Ir : ShiftIr;
      Exit1Ir:        state_d = tmsS ? UpdateIr : PauseIr;
      PauseIr:        state_d = tmsS ? Exit2Ir : PauseIr;
      Exit2Ir:        state_d = tmsS ? UpdateIr : ShiftIr;
      UpdateIr:       state_d = tmsS ? SelectDrScan : RunTestIdle;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= TestLogicReset;
    end else if (!trstNS) begin
      state_q <= TestLogicReset;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  assign tapState = state_q;

  // ========================================================================
  // Instruction register
  logic [`IR_WIDTH-1:0] irShift_q;
  logic [`IR_WIDTH-1:0] ir_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irShift_q <= `IR_CAPTURE;
    end else if (tckRise && state_q == CaptureIr) begin
      irShift_q <= `IR_CAPTURE;
    end else if (tckRise && state_q == ShiftIr) begin
      irShift_q <= {tdiS, irShift_q[`IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_q <= `OP_IDCODE;
    end else if (state_q == TestLogicReset) begin
      ir_q <= `OP_IDCODE;
    end else if (tckFall && state_q == UpdateIr) begin
      ir_q <= irShift_q;
    end
  end

  logic selBs;
  logic selId;
  logic forceBs;
  logic highZ;

  assign selBs   = ir_q == `OP_EXTEST || ir_q == `OP_SAMPLE;
  assign selId   = ir_q == `OP_IDCODE;
  assign forceBs = ir_q == `OP_EXTEST || ir_q == `OP_CLAMP;
  assign highZ   = ir_q == `OP_HIGHZ;

  // ========================================================================
  // Bypass and identification chains
  logic           bypass_q;
  logic [IDW-1:0] idShift_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_q <= 1'h0;
    end else if (tckRise && !selBs && !selId) begin
      if (state_q == CaptureDr) begin
        bypass_q <= 1'h0;
      end else if (state_q == ShiftDr) begin
        bypass_q <= tdiS;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idShift_q <= ID_VALUE;
    end else if (tckRise && selId) begin
      if (state_q == CaptureDr) begin
        idShift_q <= ID_VALUE;
      end else if (state_q == ShiftDr) begin
        idShift_q <= {tdiS, idShift_q[IDW-1:1]};
      end
    end
  end

  // ========================================================================
  // Boundary-scan chain: out cells, io data, io direction, input cells
  logic [L-1:0] bsShift_q;
  logic [L-1:0] bsHold_q;
  logic [L-1:0] bsCapture;

  assign bsCapture = {inS, coreIoOeN, ioS, coreOut};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bsShift_q <= '0;
    end else if (tckRise && selBs) begin
      if (state_q == CaptureDr) begin
        bsShift_q <= bsCapture;
      end else if (state_q == ShiftDr) begin
        bsShift_q <= {tdiS, bsShift_q[L-1:1]};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bsHold_q <= '0;
    end else if (tckFall && selBs && state_q == UpdateDr) begin
      bsHold_q <= bsShift_q;
    end
  end

  // ========================================================================
  // Test data out, changes on falling test clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tdoOut <= 1'h0;
      tdoOeN <= 1'h1;
    end else if (tckFall) begin
      tdoOeN <= !(state_q == ShiftDr || state_q == ShiftIr);
      if (state_q == ShiftIr) begin
        tdoOut <= irShift_q[0];
      end else if (selBs) begin
        tdoOut <= bsShift_q[0];
      end else if (selId) begin
        tdoOut <= idShift_q[0];
      end else begin
        tdoOut <= bypass_q;
      end
    end
  end

  // ========================================================================
  // Pin drivers, functional path unless a scan test owns the pins
  genvar g;
  generate
    for (g = 0; g < NO; g++) begin : gOut
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          outPin[g]    <= 1'h0;
          outPinOeN[g] <= 1'h0;
        end else begin
          outPin[g]    <= forceBs ? bsHold_q[g] : coreOut[g];
          outPinOeN[g] <= highZ;
        end
      end
    end
    for (g = 0; g < NB; g++) begin : gIo
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ioPinOut[g] <= 1'h0;
          ioPinOeN[g] <= 1'h1;
        end else begin
          ioPinOut[g] <= forceBs ? bsHold_q[NO+g] : coreIoOut[g];
          if (highZ) begin
            ioPinOeN[g] <= 1'h1;
          end else begin
            ioPinOeN[g] <= forceBs ? bsHold_q[NO+NB+g] : coreIoOeN[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreIn   <= '0;
      coreIoIn <= '0;
    end else begin
      coreIn   <= inS;
      coreIoIn <= ioS;
    end
  end

endmodule : jtag_data_register_path

// *** jtag_dr_checker.sv ***
`timescale 1ns/1ps
`include "jtag_dr_cfg.svh"
// ==========
// Port checks
module jtag_dr_checker (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic                       tckPin,
  input wire logic                       trstNPin,
  input wire logic                       tdoOut,
  input wire logic                       tdoOeN,
  input wire jtag_dr_pkg::tap_state_type tapState,
  input wire logic [`BS_IN_PINS-1:0]     inPin,
  input wire logic [`BS_IN_PINS-1:0]     coreIn,
  input wire logic [`BS_OUT_PINS-1:0]    outPinOeN,
  input wire logic [`BS_IO_PINS-1:0]     ioPinOeN
);
  import jtag_dr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_tdo_drive_shift: assert property (
    !tdoOeN |-> tapState inside {ShiftDr, Exit1Dr, ShiftIr, Exit1Ir})
    else $error("tdo driven outside shift");
  a_tdo_low_phase: assert property (
    $changed(tdoOut) |-> !tckPin && !$past(tckPin, 3))
    else $error("tdo changed in high tck phase");
  a_core_in_path: assert property (
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> coreIn == $past(inPin, 3))
    else $error("core input path disturbed");
  a_highz_floats_all: assert property (
    |outPinOeN |-> &outPinOeN && &ioPinOeN)
    else $error("partial output float");
  a_trst_forces_reset: assert property (
    !trstNPin [*4] |=> tapState == TestLogicReset)
    else $error("test reset not applied");
  a_capture_entry: assert property (
    $changed(tapState) && tapState == CaptureDr |-> $past(tapState) == SelectDrScan)
    else $error("bad capture entry");
  a_update_entry: assert property (
    $changed(tapState) && tapState == UpdateDr |-> $past(tapState) inside {Exit1Dr, Exit2Dr})
    else $error("bad update entry");
  a_state_hold: assert property (
    $changed(tapState) |=> $stable(tapState) [*8])
    else $error("state changed too fast");

  c_update: cover property (tapState == UpdateDr);
  c_highz: cover property (&outPinOeN);
  c_shift_out: cover property ($fell(tdoOeN));
endmodule : jtag_dr_checker

// *** jtag_tester.sv ***
`timescale 1ns/1ps
// ==========
// Tester model: drives the link, reads TDO
module jtag_tester (
  input  wire logic clk,
  input  wire logic tdoOut,
  output logic      tckPin,
  output logic      tmsPin,
  output logic      tdiPin,
  output logic      trstNPin
);
  initial begin
    tckPin = 1'h0;
    tmsPin = 1'h1;
    tdiPin = 1'h0;
    trstNPin = 1'h1;
  end

  // One 25 clk TCK period, entered at a falling clk edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tmsPin = tms;
    tdiPin = tdi;
    repeat (6) @(negedge clk);
    tckPin = 1'h1;
    repeat (12) @(negedge clk);
    tckPin = 1'h0;
    repeat (7) @(negedge clk);
    tdo = tdoOut;
  endtask : step

  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int w, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'h1, 1'h0, t);
    if (ir) step(1'h1, 1'h0, t);
    step(1'h0, 1'h0, t);
    step(1'h0, 1'h0, t);
    dout[0] = t;
    for (int i = 0; i < w; i++) begin
      step(i == w - 1, din[i], t);
      if (i < w - 1) dout[i + 1] = t;
    end
    step(1'h1, ~din[0], t);
    step(1'h0, din[0], t);
  endtask : scan

  task automatic pulse_trst;
    trstNPin = 1'h0;
    repeat (10) @(negedge clk);
    trstNPin = 1'h1;
    repeat (4) @(negedge clk);
  endtask : pulse_trst
endmodule : jtag_tester

// *** test_jtag_data_register_path.sv ***
`timescale 1ns/1ps
`include "jtag_dr_cfg.svh"
// ==========
// Bench top
module test_jtag_data_register_path;
  import jtag_dr_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic tckPin, tmsPin, tdiPin, trstNPin, tdoOut, tdoOeN;
  tap_state_type tapState;
  logic [`BS_IN_PINS-1:0] inPin = 4'ha, coreIn;
  logic [`BS_OUT_PINS-1:0] coreOut = 4'h5, outPin, outPinOeN;
  logic [`BS_IO_PINS-1:0] coreIoOut = 2'h1, coreIoOeN = 2'h2, coreIoIn, ioExt = 2'h3;
  logic [`BS_IO_PINS-1:0] ioPinOut, ioPinOeN;
  wire [`BS_IO_PINS-1:0] ioPinIn = (~ioPinOeN & ioPinOut) | (ioPinOeN & ioExt);
  logic [31:0] dout;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  jtag_tester i_jtag_tester (.clk(clk), .tdoOut(tdoOut), .tckPin(tckPin),
    .tmsPin(tmsPin), .tdiPin(tdiPin), .trstNPin(trstNPin));

  jtag_data_register_path i_jtag_data_register_path (.clk(clk), .sys_rst(sys_rst),
    .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .trstNPin(trstNPin),
    .tdoOut(tdoOut), .tdoOeN(tdoOeN), .tapState(tapState), .inPin(inPin),
    .coreIn(coreIn), .coreOut(coreOut), .outPin(outPin), .outPinOeN(outPinOeN),
    .coreIoOut(coreIoOut), .coreIoOeN(coreIoOeN), .coreIoIn(coreIoIn),
    .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOeN(ioPinOeN));

  // ==========
  // Checks and scenarios
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_idcode;
    logic        t;
    logic [31:0] idExp;
    idExp = {`ID_VERSION, `ID_SEGMENT, `ID_PTYPE, `ID_COMPONENT, `ID_MAKER, 1'h1};
    i_jtag_tester.step(1'h0, 1'h0, t);
    i_jtag_tester.scan(1'h0, `ID_WIDTH, 32'h0, dout);
    check("idcode", dout, idExp);
    $display("test idcode done");
  endtask : test_idcode

  task automatic test_bypass;
    i_jtag_tester.scan(1'h1, `IR_WIDTH, `OP_BYPASS, dout);
    check("ir capture", dout, `IR_CAPTURE);
    i_jtag_tester.scan(1'h0, 4, 32'hb, dout);
    check("bypass path", dout, 32'h6);
    check("bypass pins", outPin, coreOut);
    $display("test bypass done");
  endtask : test_bypass

  task automatic test_highz;
    i_jtag_tester.scan(1'h1, `IR_WIDTH, `OP_HIGHZ, dout);
    check("out float", outPinOeN, 4'hf);
    check("io float", ioPinOeN, 2'h3);
    i_jtag_tester.scan(1'h0, 4, 32'h5, dout);
    check("highz path", dout, 32'ha);
    $display("test highz done");
  endtask : test_highz

  task automatic test_sample;
    i_jtag_tester.scan(1'h1, `IR_WIDTH, `OP_SAMPLE, dout);
    i_jtag_tester.scan(1'h0, `BS_LEN, 32'h369, dout);
    check("sample capture", dout, 32'hab5);
    check("sample pins", outPin, coreOut);
    check("sample dir", ioPinOeN, coreIoOeN);
    check("sample io in", coreIoIn, 2'h3);
    $display("test sample done");
  endtask : test_sample

  task automatic test_extest;
    ioExt = 2'h0;
    inPin = 4'h3;
    i_jtag_tester.scan(1'h1, `IR_WIDTH, `OP_EXTEST, dout);
    check("preload out", outPin, 4'h9);
    check("preload dir", ioPinOeN, 2'h1);
    i_jtag_tester.scan(1'h0, `BS_LEN, 32'hc3a, dout);
    check("extest capture", dout, 32'h3a5);
    check("extest out", outPin, 4'ha);
    check("extest io", ioPinOut, 2'h3);
    check("extest dir", ioPinOeN, 2'h0);
    $display("test extest done");
  endtask : test_extest

  task automatic test_clamp;
    coreOut = 4'h6;
    i_jtag_tester.scan(1'h1, `IR_WIDTH, `OP_CLAMP, dout);
    check("clamp out", outPin, 4'ha);
    check("clamp io", ioPinOut, 2'h3);
    i_jtag_tester.scan(1'h0, 4, 32'h3, dout);
    check("clamp path", dout, 32'h6);
    $display("test clamp done");
  endtask : test_clamp

  task automatic test_trst;
    i_jtag_tester.pulse_trst();
    check("trst state", tapState, TestLogicReset);
    test_idcode();
    $display("test trst done");
  endtask : test_trst

  task automatic results;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failCount++;
      results();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    repeat (4) @(negedge clk);
    test_idcode();
    test_bypass();
    test_highz();
    test_sample();
    test_extest();
    test_clamp();
    test_trst();
    results();
  end
endmodule : test_jtag_data_register_path

bind jtag_data_register_path jtag_dr_checker i_jtag_dr_checker (.clk(clk),
  .sys_rst(sys_rst), .tckPin(tckPin), .trstNPin(trstNPin), .tdoOut(tdoOut),
  .tdoOeN(tdoOeN), .tapState(tapState), .inPin(inPin), .coreIn(coreIn),
  .outPinOeN(outPinOeN), .ioPinOeN(ioPinOeN));
